/* File: hdl/bcic_pkg.sv */
// Constants and carrier types for the bridge ID and command bank
package bcic_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0]  OFS_ID     = 8'h00;
  localparam logic [7:0]  OFS_CMD    = 8'h04;
  // ==========================================
  // Command bit positions
  localparam int          CMD_IO     = 0;
  localparam int          CMD_MEM    = 1;
  localparam int          CMD_MST    = 2;
  localparam int          CMD_SPC    = 3;
  localparam int          CMD_MWI    = 4;
  localparam int          CMD_VGA    = 5;
  localparam int          CMD_PER    = 6;
  localparam int          CMD_WAIT   = 7;
  localparam int          CMD_SERR   = 8;
  localparam int          CMD_B2B    = 9;
  localparam int          CMD_INTD   = 10;
  localparam int          STS_MDPE   = 24;
  // ==========================================
  // Reset value, writable mask and unmapped read value
  localparam logic [15:0] CMD_RESET  = 16'h0000;
  localparam logic [15:0] CMD_WMASK  = 16'h0547;
  localparam logic [31:0] RD_NONE    = 32'h0000_0000;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bcic_cfg_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } bcic_cfg_rsp_t;
endpackage

/* File: hdl/bcic_top.sv */
// Bridge identification and command register bank with traffic gating
`timescale 1ns/100ps
// ==========================================
module bcic_top import bcic_pkg::*; #(
  parameter logic [15:0] MAKER_ID = 16'h5A5A, // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h0C01  // Arbitrary value
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Configuration access
  input  wire bcic_cfg_req_t cfg_req,
  output      bcic_cfg_rsp_t cfg_rsp,
  // Primary side targets
  input  wire logic          pri_io_req,
  output      logic          pri_io_claim,
  input  wire logic          pri_mem_rd_req,
  output      logic          pri_mem_rd_claim,
  // Secondary side and upstream mastering
  input  wire logic          sec_req,
  output      logic          sec_claim,
  input  wire logic          fwd_req,
  output      logic          up_req_valid,
  // Error events
  input  wire logic          pri_cpl_poisoned,
  input  wire logic          pri_wr_poisoned,
  input  wire logic          pri_parity_err,
  input  wire logic          err_msg_req,
  output      logic          err_msg_send,
  // Legacy interrupt
  input  wire logic          irq_src,
  output      logic          legacy_interrupt_a_pin_n
);
  // ==========================================
  // Reset release
  logic        rst_meta;
  logic        rst_n_i;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n_i  <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_i  <= rst_meta;
    end
  end

  // ==========================================
  // Decode
  logic [15:0] cmd_q;
  logic        flag;
  wire         cfg_rd   = cfg_req.valid & ~cfg_req.write;
  wire         cfg_wr   = cfg_req.valid & cfg_req.write;
  wire         hit_id   = cfg_req.addr == OFS_ID;
  wire         hit_cmd  = cfg_req.addr == OFS_CMD;
  wire         cmd_wr   = cfg_wr & hit_cmd;
  // Only writable bits can ever change; the rest stay at reset zero
  wire  [15:0] wmask_be = CMD_WMASK & {{8{cfg_req.be[1]}},
                                       {8{cfg_req.be[0]}}};
  wire  [15:0] next_cmd = cmd_wr ?
                          ((cmd_q & ~wmask_be) |
                           (cfg_req.wdata[15:0] & wmask_be)) : cmd_q;

  // ==========================================
  // Poisoned data flag
  wire poison_evt = pri_cpl_poisoned | pri_wr_poisoned | pri_parity_err;
  wire flag_set   = cmd_q[CMD_PER] & poison_evt;
  wire flag_clr   = cmd_wr & cfg_req.be[3] & cfg_req.wdata[STS_MDPE];
  // Set beats a clear in the same cycle so no event is lost
  wire next_flag  = flag_set | (flag & ~flag_clr);

  // ==========================================
  // Read mux
  wire [31:0] id_word  = {PART_ID, MAKER_ID};
  wire [31:0] cmd_word = {7'h00, flag, 8'h00, cmd_q};
  wire [31:0] rd_word  = hit_id  ? id_word  :
                         hit_cmd ? cmd_word : RD_NONE;

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_RESET;
      flag  <= 1'b0;
    end else begin
      cmd_q <= next_cmd;
      flag  <= next_flag;
    end
  end

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.ack <= cfg_req.valid;
      if (cfg_rd) begin
        cfg_rsp.rdata <= rd_word;
      end
    end
  end

  // ==========================================
  // Traffic gating
  // Host must set these before traffic flows; no queuing meanwhile
  assign pri_io_claim     = pri_io_req & cmd_q[CMD_IO];
  assign pri_mem_rd_claim = pri_mem_rd_req & cmd_q[CMD_MEM];
  assign sec_claim        = sec_req & cmd_q[CMD_MST];
  assign up_req_valid     = fwd_req & cmd_q[CMD_MST];
  assign err_msg_send     = err_msg_req & cmd_q[CMD_SERR];

  // Registered pin avoids glitches on the shared interrupt line
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      legacy_interrupt_a_pin_n <= 1'b1;
    end else begin
      legacy_interrupt_a_pin_n <= ~(irq_src & ~cmd_q[CMD_INTD]);
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_i);

  sequence s_cmd_wr_full;
    cfg_wr && hit_cmd && cfg_req.be == 4'hF;
  endsequence
  sequence s_io_off;
    cfg_wr && hit_cmd && cfg_req.be[0] && !cfg_req.wdata[CMD_IO];
  endsequence
  sequence s_mem_on;
    cfg_wr && hit_cmd && cfg_req.be[0] && cfg_req.wdata[CMD_MEM];
  endsequence

  property p_maker_id;
    cfg_rd && hit_id |=> cfg_rsp.ack && cfg_rsp.rdata[15:0] == MAKER_ID;
  endproperty
  a_maker_id: assert property (p_maker_id)
    else $error("maker code wrong");

  property p_part_id;
    cfg_rd && hit_id |=> cfg_rsp.rdata[31:16] == PART_ID;
  endproperty
  a_part_id: assert property (p_part_id)
    else $error("part code wrong");

  property p_io_gate;
    s_io_off ##1 pri_io_req |-> !pri_io_claim;
  endproperty
  a_io_gate: assert property (p_io_gate)
    else $error("io claimed while disabled");

  property p_mem_gate;
    s_mem_on ##1 (pri_mem_rd_req && !cfg_wr) |-> pri_mem_rd_claim;
  endproperty
  a_mem_gate: assert property (p_mem_gate)
    else $error("memory read not claimed");

  property p_mst_gate;
    !cmd_q[CMD_MST] |-> !up_req_valid && !sec_claim;
  endproperty
  a_mst_gate: assert property (p_mst_gate)
    else $error("initiator traffic while disabled");

  property p_spc_zero;
    s_cmd_wr_full ##2 (cfg_rd && hit_cmd) |=> !cfg_rsp.rdata[CMD_SPC];
  endproperty
  a_spc_zero: assert property (p_spc_zero)
    else $error("broadcast bit set");

  property p_mwi_zero;
    s_cmd_wr_full |=> !cmd_q[CMD_MWI];
  endproperty
  a_mwi_zero: assert property (p_mwi_zero)
    else $error("line write bit set");

  property p_unsup_zero;
    s_cmd_wr_full |=> !cmd_q[CMD_VGA] && !cmd_q[CMD_WAIT]
                      && !cmd_q[CMD_B2B];
  endproperty
  a_unsup_zero: assert property (p_unsup_zero)
    else $error("unsupported bit set");

  property p_poison_set;
    cmd_q[CMD_PER] && poison_evt |=> flag;
  endproperty
  a_poison_set: assert property (p_poison_set)
    else $error("poison flag not set");

  property p_err_gate;
    err_msg_req && !cmd_q[CMD_SERR] |-> !err_msg_send;
  endproperty
  a_err_gate: assert property (p_err_gate)
    else $error("error message while disabled");

  property p_irq_block;
    cmd_q[CMD_INTD] |=> legacy_interrupt_a_pin_n;
  endproperty
  a_irq_block: assert property (p_irq_block)
    else $error("interrupt asserted while blocked");

  property p_poison_only;
    !cmd_q[CMD_PER] && !flag |=> !flag;
  endproperty
  a_poison_only: assert property (p_poison_only)
    else $error("poison flag set while disabled");

  property p_upper_zero;
    s_cmd_wr_full |=> cmd_q[15:11] == 5'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("reserved bits written");

  property p_set_wins;
    flag_set && flag_clr |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag lost on clear");

  // Open traffic gates pass requests in the same cycle, the interrupt one cycle later; nothing is queued
  property p_io_open;
    cmd_q[CMD_IO] && pri_io_req |-> pri_io_claim;
  endproperty
  a_io_open: assert property (p_io_open)
    else $error("io not claimed while enabled");

  property p_io_shut;
    !cmd_q[CMD_IO] |-> !pri_io_claim;
  endproperty
  a_io_shut: assert property (p_io_shut)
    else $error("io claimed after disable");

  property p_mem_shut;
    !cmd_q[CMD_MEM] |-> !pri_mem_rd_claim;
  endproperty
  a_mem_shut: assert property (p_mem_shut)
    else $error("memory read claimed while disabled");

  property p_fwd_open;
    cmd_q[CMD_MST] && fwd_req |-> up_req_valid;
  endproperty
  a_fwd_open: assert property (p_fwd_open)
    else $error("upstream request dropped");

  property p_sec_open;
    cmd_q[CMD_MST] && sec_req |-> sec_claim;
  endproperty
  a_sec_open: assert property (p_sec_open)
    else $error("secondary request not claimed");

  property p_err_open;
    cmd_q[CMD_SERR] && err_msg_req |-> err_msg_send;
  endproperty
  a_err_open: assert property (p_err_open)
    else $error("error message dropped");

  property p_irq_pass;
    !cmd_q[CMD_INTD] && irq_src |=> !legacy_interrupt_a_pin_n;
  endproperty
  a_irq_pass: assert property (p_irq_pass)
    else $error("interrupt not asserted");

  property p_ro_read;
    cfg_rd && hit_cmd |=> !cfg_rsp.rdata[CMD_MWI] &&
      !cfg_rsp.rdata[CMD_VGA] && !cfg_rsp.rdata[CMD_WAIT] &&
      !cfg_rsp.rdata[CMD_B2B];
  endproperty
  a_ro_read: assert property (p_ro_read)
    else $error("read-only command bit reads one");

  property p_upper_read;
    cfg_rd && hit_cmd |=> cfg_rsp.rdata[15:11] == 5'h00;
  endproperty
  a_upper_read: assert property (p_upper_read)
    else $error("upper command bits read nonzero");

  property p_other_wr;
    cfg_wr && !hit_cmd |=> $stable(cmd_q);
  endproperty
  a_other_wr: assert property (p_other_wr)
    else $error("command changed by foreign write");

  property p_lane_hold;
    cmd_wr && !cfg_req.be[1] |=> cmd_q[15:8] == $past(cmd_q[15:8]);
  endproperty
  a_lane_hold: assert property (p_lane_hold)
    else $error("disabled byte lane written");

  property p_rd_other;
    cfg_rd && !hit_id && !hit_cmd |=> cfg_rsp.rdata == RD_NONE;
  endproperty
  a_rd_other: assert property (p_rd_other)
    else $error("unmapped read not zero");

  property p_flag_clear;
    flag_clr && !flag_set |=> !flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("poison flag not cleared");

  property p_flag_read;
    flag && cfg_rd && hit_cmd |=> cfg_rsp.rdata[STS_MDPE];
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("poison flag not readable");
endmodule

/* File: verif/bcic_host.sv */
// Host model issuing configuration accesses to the bank
`timescale 1ns/100ps
module bcic_host import bcic_pkg::*; (
  // Clock
  input  wire logic          clk,
  // Configuration access
  output      bcic_cfg_req_t cfg_req,
  input  wire bcic_cfg_rsp_t cfg_rsp
);
  initial cfg_req = '0;
  // ==========================================
  // One access; released lines show junk, not the last value
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    #1 cfg_req = {1'b1, w, a, be, d};
    @(posedge clk);
    #1 cfg_req = {1'b0, ~w, ~a, ~be, ~d};
    q = cfg_rsp.ack ? cfg_rsp.rdata : 32'hDEAD_BEEF;
  endtask
endmodule

/* File: verif/bcic_top_tb.sv */
// Self-checking bench for the ID and command bank
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("Error at %0t: got %h exp %h", $time, g, e); \
  end end
module bcic_top_tb import bcic_pkg::*; ;
  localparam logic [15:0] MK = 16'h1357; // Arbitrary value
  localparam logic [15:0] PT = 16'h2468; // Arbitrary value
  logic          clk = 1'b0;
  logic          reset_n = 1'b0;
  bcic_cfg_req_t cfg_req;
  bcic_cfg_rsp_t cfg_rsp;
  logic [4:0]    rq = 5'h00; // io, mem, sec, fwd, err
  logic [2:0]    ev = 3'h0;  // cpl, wr, parity
  logic          irq_src = 1'b0;
  wire  [4:0]    cl;
  logic          pin_n;
  logic [31:0]   q;
  int            n_mismatch = 0;
  int            n_compared = 0;
  int            cyc = 0;
  bcic_top #(.MAKER_ID(MK), .PART_ID(PT)) u_bcic_top (
    .clk(clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .pri_io_req(rq[0]), .pri_io_claim(cl[0]),
    .pri_mem_rd_req(rq[1]), .pri_mem_rd_claim(cl[1]),
    .sec_req(rq[2]), .sec_claim(cl[2]), .fwd_req(rq[3]),
    .up_req_valid(cl[3]), .pri_cpl_poisoned(ev[0]),
    .pri_wr_poisoned(ev[1]), .pri_parity_err(ev[2]),
    .err_msg_req(rq[4]), .err_msg_send(cl[4]), .irq_src(irq_src),
    .legacy_interrupt_a_pin_n(pin_n));
  bcic_host u_bcic_host (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
  // ==========================================
  // Access helpers
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    u_bcic_host.acc(1'b1, a, be, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_bcic_host.acc(1'b0, a, 4'h0, 32'h0, q);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rd(OFS_ID);
    `CHK(q, ({PT, MK}))
    rd(OFS_CMD);
    `CHK(q, 32'h0000_0000)
    `CHK(cl, 5'h00)
  endtask
  task automatic t_ro;
    wr(OFS_CMD, 4'hF, 32'h0000_FFFF);
    rd(OFS_CMD);
    `CHK(q, 32'h0000_0547)
    wr(OFS_ID, 4'hF, 32'hFFFF_FFFF);
    rd(OFS_ID);
    `CHK(q, ({PT, MK}))
    rd(8'h08);
    `CHK(q, 32'h0000_0000)
  endtask
  task automatic t_gates;
    int         b[4] = '{0, 1, 2, 8};
    logic [4:0] e[4] = '{5'h01, 5'h02, 5'h0C, 5'h10};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CMD, 4'h3, 32'h1 << b[i]);
      `CHK(cl, e[i])
    end
    // Low lane only; bit 8 must survive
    wr(OFS_CMD, 4'h1, 32'h0000_0007);
    `CHK(cl, 5'h1F)
    // Open gates must not invent requests
    rq = 5'h00;
    #1;
    `CHK(cl, 5'h00)
    @(posedge clk);
    #1 rq = 5'h1F;
  endtask
  task automatic t_irq;
    irq_src = 1'b1;
    @(posedge clk);
    #1;
    `CHK(pin_n, 1'b0)
    wr(OFS_CMD, 4'h3, 32'h0000_0400);
    @(posedge clk);
    #1;
    `CHK(pin_n, 1'b1)
    irq_src = 1'b0;
  endtask
  task automatic t_poison;
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CMD, 4'h3, i ? 32'h0000_0040 : 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
        ev[k] = 1'b1;
        @(posedge clk);
        #1 ev[k] = 1'b0;
        rd(OFS_CMD);
        `CHK(q[24], i[0])
        wr(OFS_CMD, 4'h8, 32'h0100_0000);
      end
    end
    rd(OFS_CMD);
    `CHK(q, 32'h0000_0040)
    // Event and clear in one cycle: the event must win
    fork
      wr(OFS_CMD, 4'h8, 32'h0100_0000);
      begin
        @(posedge clk);
        #1 ev[0] = 1'b1;
        @(posedge clk);
        #1 ev[0] = 1'b0;
      end
    join
    rd(OFS_CMD);
    `CHK(q[24], 1'b1)
  endtask
  // ==========================================
  // Clock, hang guard and verdict
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 rq = 5'h1F;
    t_reset();
    t_ro();
    t_gates();
    t_irq();
    t_poison();
    summarize();
  end
endmodule
